// file: inc/fkwe_regs.vh
// constants for the flash key, write and erase sequencer
// assumes a 25 MHz clock and a flash array sampled on the same clock
`ifndef FKWE_REGS_VH
`define FKWE_REGS_VH

// ****************************************
// unlock codes
// ****************************************
`define FKWE_KEY_FIRST      8'hA5
`define FKWE_KEY_SECOND     8'hF1

// ****************************************
// array geometry
// ****************************************
`define FKWE_ADDR_W         16
`define FKWE_PAGE_BITS      9
`define FKWE_ERASED_BYTE    8'hFF

// ****************************************
// key tracker states
// ****************************************
`define FKWE_KS_LOCKED      2'h0
`define FKWE_KS_FIRST       2'h1
`define FKWE_KS_OPEN        2'h2
`define FKWE_KS_DISABLED    2'h3

// ****************************************
// timing
// ****************************************
`define FKWE_CLK_PERIOD_NS  40
`define FKWE_PROG_TIME_NS   40000
`define FKWE_ERASE_TIME_NS  20000000
`define FKWE_PROG_CYCLES    ((`FKWE_PROG_TIME_NS + `FKWE_CLK_PERIOD_NS - 1) / `FKWE_CLK_PERIOD_NS)
`define FKWE_ERASE_CYCLES   ((`FKWE_ERASE_TIME_NS + `FKWE_CLK_PERIOD_NS - 1) / `FKWE_CLK_PERIOD_NS)
`define FKWE_TIMER_W        20

`endif

// file: verilog/fkwe_op_timer.v
// down counter that times one program or erase operation
// assumes start_i is a one-cycle pulse on the same clock, count_i >= 1
module fkwe_op_timer #(
    parameter W = 20
) (
    input  wire         ref_clk_i,
    input  wire         rst_b_i,
    input  wire         start_i,
    input  wire [W-1:0] count_i,
    output wire         busy_o,
    output reg          done_o
);

    reg [W-1:0] cnt_r;

    // ****************************************
    // count down to zero
    // ****************************************
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r  <= {W{1'b0}};
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_r <= count_i;
            end else if (cnt_r != {W{1'b0}}) begin
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
                if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign busy_o = (cnt_r != {W{1'b0}});

endmodule // fkwe_op_timer

// file: verilog/fkwe_ctrl.v
// key-protected program and erase sequencer for on-chip program memory
// assumes cpu control bits, stores and flash array all on ref_clk_i;
// sys_rst_i is the one-cycle system reset event from the reset controller
//
// Summary of operation
// - erase clears whole 512-byte page to ones
// - programming only clears bits, never sets
// - operations timed internally, no polling needed
// - cpu stalled for whole operation
// - keys A5 then F1 unlock one operation
// - no time limit between key writes
// - wrong or misordered key disables until reset
// - operation before unlock disables until reset
// - lock again after every operation
// - write enable steers stores to flash
// - erase targets page of next store, data ignored
// - byte mode programs each store
// - block mode buffers even, programs on odd
// - block program takes single-byte time
// - supply monitor off gives error reset
// - monitor or its reset source off errors
// - erase needs erase and write enables
// - error reset sets flash error indicator
`include "fkwe_regs.vh"

module fkwe_ctrl #(
    parameter PROG_CYCLES  = `FKWE_PROG_CYCLES,
    parameter ERASE_CYCLES = `FKWE_ERASE_CYCLES
) (
    input  wire        ref_clk_i,
    input  wire        rst_b_i,
    input  wire        sys_rst_i,
    input  wire        key_wr_i,
    input  wire [7:0]  key_data_i,
    input  wire        store_write_enable_i,
    input  wire        store_erase_enable_i,
    input  wire        block_write_select_i,
    input  wire        supply_monitor_on_i,
    input  wire        supply_reset_src_en_i,
    input  wire        st_valid_i,
    input  wire [15:0] st_addr_i,
    input  wire [7:0]  st_data_i,
    input  wire [15:0] flash_rdata_i,
    output reg         xram_we_o,
    output reg  [15:0] xram_addr_o,
    output reg  [7:0]  xram_wdata_o,
    output reg  [15:0] flash_addr_o,
    output reg  [15:0] flash_wdata_o,
    output reg  [1:0]  flash_bmask_o,
    output reg         flash_prog_o,
    output reg         flash_erase_o,
    output wire        cpu_stall_o,
    output wire [1:0]  key_state_o,
    output reg         flash_error_reset_o,
    output reg         flash_error_indicator_o
);

    localparam TW = `FKWE_TIMER_W;
    localparam [TW-1:0] PROG_CNT  = PROG_CYCLES[TW-1:0];
    localparam [TW-1:0] ERASE_CNT = ERASE_CYCLES[TW-1:0];

    reg  [1:0]    key_state_r;
    reg  [1:0]    key_state_nxt;
    reg  [7:0]    even_buf_r;
    reg           start_r;
    reg  [TW-1:0] start_cnt_r;
    wire          timer_busy;
    wire          timer_done;
    wire          busy;
    wire          flash_store;
    wire          supply_bad;

    // ****************************************
    // helpers
    // ****************************************
    function [7:0] prog_merge;
        input [7:0] old_byte;
        input [7:0] new_byte;
        begin
            prog_merge = old_byte & new_byte;
        end
    endfunction

    assign busy        = start_r | timer_busy | flash_prog_o | flash_erase_o;
    assign cpu_stall_o = busy;
    assign flash_store = st_valid_i & store_write_enable_i & ~busy;
    assign supply_bad  = ~supply_monitor_on_i | ~supply_reset_src_en_i;
    assign key_state_o = key_state_r;

    // ****************************************
    // key tracker
    // ****************************************
    always @* begin
        key_state_nxt = key_state_r;
        case (key_state_r)
            `FKWE_KS_LOCKED: begin
                if (key_wr_i) begin
                    if (key_data_i == `FKWE_KEY_FIRST) begin
                        key_state_nxt = `FKWE_KS_FIRST;
                    end else begin
                        key_state_nxt = `FKWE_KS_DISABLED;
                    end
                end else if (flash_store && !supply_bad) begin
                    key_state_nxt = `FKWE_KS_DISABLED;
                end
            end
            `FKWE_KS_FIRST: begin
                if (key_wr_i) begin
                    if (key_data_i == `FKWE_KEY_SECOND) begin
                        key_state_nxt = `FKWE_KS_OPEN;
                    end else begin
                        key_state_nxt = `FKWE_KS_DISABLED;
                    end
                end else if (flash_store && !supply_bad) begin
                    key_state_nxt = `FKWE_KS_DISABLED;
                end
            end
            `FKWE_KS_OPEN: begin
                if (key_wr_i) begin
                    key_state_nxt = `FKWE_KS_DISABLED;
                end else if (flash_store && !supply_bad) begin
                    key_state_nxt = `FKWE_KS_LOCKED;
                end
            end
            default: begin
                key_state_nxt = `FKWE_KS_DISABLED;
            end
        endcase
    end

    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            key_state_r <= `FKWE_KS_LOCKED;
        end else if (sys_rst_i) begin
            key_state_r <= `FKWE_KS_LOCKED;
        end else begin
            key_state_r <= key_state_nxt;
        end
    end

    // ****************************************
    // store steering and operation launch
    // ****************************************
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xram_we_o     <= 1'b0;
            xram_addr_o   <= 16'h0000;
            xram_wdata_o  <= 8'h00;
            flash_addr_o  <= 16'h0000;
            flash_wdata_o <= 16'hFFFF;
            flash_bmask_o <= 2'h0;
            flash_prog_o  <= 1'b0;
            flash_erase_o <= 1'b0;
            even_buf_r    <= `FKWE_ERASED_BYTE;
            start_r       <= 1'b0;
            start_cnt_r   <= PROG_CNT;
        end else if (sys_rst_i) begin
            xram_we_o     <= 1'b0;
            flash_prog_o  <= 1'b0;
            flash_erase_o <= 1'b0;
            even_buf_r    <= `FKWE_ERASED_BYTE;
            start_r       <= 1'b0;
        end else begin
            xram_we_o <= 1'b0;
            start_r   <= 1'b0;
            if (timer_done) begin
                flash_prog_o  <= 1'b0;
                flash_erase_o <= 1'b0;
                flash_bmask_o <= 2'h0;
            end
            if (st_valid_i && !store_write_enable_i && !busy) begin
                xram_we_o    <= 1'b1;
                xram_addr_o  <= st_addr_i;
                xram_wdata_o <= st_data_i;
            end
            if (flash_store && !supply_bad && key_state_r == `FKWE_KS_OPEN && !key_wr_i) begin
                if (store_erase_enable_i) begin
                    // whole page, store data ignored
                    flash_addr_o  <= {st_addr_i[15:`FKWE_PAGE_BITS],
                                      {`FKWE_PAGE_BITS{1'b0}}};
                    flash_wdata_o <= {`FKWE_ERASED_BYTE, `FKWE_ERASED_BYTE};
                    flash_bmask_o <= 2'h3;
                    flash_erase_o <= 1'b1;
                    start_r       <= 1'b1;
                    start_cnt_r   <= ERASE_CNT;
                end else if (block_write_select_i && !st_addr_i[0]) begin
                    even_buf_r <= st_data_i;
                end else if (block_write_select_i) begin
                    flash_addr_o  <= {st_addr_i[15:1], 1'b0};
                    flash_wdata_o <= {prog_merge(flash_rdata_i[15:8], st_data_i),
                                      prog_merge(flash_rdata_i[7:0], even_buf_r)};
                    flash_bmask_o <= 2'h3;
                    flash_prog_o  <= 1'b1;
                    start_r       <= 1'b1;
                    start_cnt_r   <= PROG_CNT;
                end else begin
                    flash_addr_o  <= st_addr_i;
                    flash_wdata_o <= st_addr_i[0] ?
                                     {prog_merge(flash_rdata_i[15:8], st_data_i), 8'hFF} :
                                     {8'hFF, prog_merge(flash_rdata_i[7:0], st_data_i)};
                    flash_bmask_o <= st_addr_i[0] ? 2'h2 : 2'h1;
                    flash_prog_o  <= 1'b1;
                    start_r       <= 1'b1;
                    start_cnt_r   <= PROG_CNT;
                end
            end
        end
    end

    // ****************************************
    // flash error reset and its indicator
    // ****************************************
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flash_error_reset_o     <= 1'b0;
            flash_error_indicator_o <= 1'b0;
        end else if (sys_rst_i) begin
            flash_error_indicator_o <= flash_error_reset_o;
            flash_error_reset_o     <= 1'b0;
        end else if (flash_store && supply_bad) begin
            flash_error_reset_o <= 1'b1;
        end
    end

    // ****************************************
    // operation timer
    // ****************************************
    fkwe_op_timer #(
        .W (TW)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .start_i   (start_r),
        .count_i   (start_cnt_r),
        .busy_o    (timer_busy),
        .done_o    (timer_done)
    );

endmodule // fkwe_ctrl

// file: bench/fkwe_ctrl_assertions.sv
// checker for the key, write and erase sequencer
// assumes bind to fkwe_ctrl run with short operation counts
module fkwe_ctrl_chk (
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic        sys_rst_i,
    input wire logic        key_wr_i,
    input wire logic        store_write_enable_i,
    input wire logic        store_erase_enable_i,
    input wire logic        supply_monitor_on_i,
    input wire logic        supply_reset_src_en_i,
    input wire logic        st_valid_i,
    input wire logic [7:0]  st_data_i,
    input wire logic [15:0] flash_rdata_i,
    input wire logic        xram_we_o,
    input wire logic [7:0]  xram_wdata_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic [15:0] flash_wdata_o,
    input wire logic [1:0]  flash_bmask_o,
    input wire logic        flash_prog_o,
    input wire logic        flash_erase_o,
    input wire logic        cpu_stall_o,
    input wire logic [1:0]  key_state_o,
    input wire logic        flash_error_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire fst = st_valid_i && !cpu_stall_o && store_write_enable_i && !key_wr_i && !sys_rst_i;
    a_stall_during_op: assert property ((flash_prog_o || flash_erase_o) |-> cpu_stall_o)
        else $error("stall low during op");
    a_prog_timed: assert property ($rose(flash_prog_o) |-> ##[2:40] !flash_prog_o)
        else $error("program not ended");
    a_erase_timed: assert property ($rose(flash_erase_o) |-> flash_erase_o[*8] ##[1:40] !flash_erase_o)
        else $error("erase length wrong");
    a_relock_after_op: assert property ($rose(flash_prog_o) || $rose(flash_erase_o) |-> key_state_o == 2'h0)
        else $error("not relocked");
    a_disabled_holds: assert property (key_state_o == 2'h3 && !sys_rst_i |=> key_state_o == 2'h3)
        else $error("disabled state left");
    a_no_op_locked: assert property (fst && key_state_o != 2'h2 |=> !flash_prog_o && !flash_erase_o)
        else $error("op while locked");
    a_erase_enables: assert property ($rose(flash_erase_o) |->
        $past(store_erase_enable_i) && $past(store_write_enable_i))
        else $error("erase without enables");
    a_page_base: assert property ($rose(flash_erase_o) |-> flash_addr_o[8:0] == 9'h000)
        else $error("erase not page based");
    a_xram_steer: assert property (st_valid_i && !cpu_stall_o &&
        !store_write_enable_i && !key_wr_i && !sys_rst_i |=>
        xram_we_o && xram_wdata_o == $past(st_data_i))
        else $error("store not sent to xram");
    a_monitor_err: assert property (fst &&
        !(supply_monitor_on_i && supply_reset_src_en_i) |=>
        flash_error_reset_o && !flash_prog_o && !flash_erase_o)
        else $error("no error reset");
    a_prog_clears: assert property ($rose(flash_prog_o) |->
        ({{8{flash_bmask_o[1]}}, {8{flash_bmask_o[0]}}} & flash_wdata_o
          & ~flash_rdata_i) == 16'h0000)
        else $error("program sets a bit");
    a_stall_release: assert property (($fell(flash_prog_o) || $fell(flash_erase_o)) &&
        !$past(sys_rst_i) |-> !cpu_stall_o)
        else $error("stall outlasts op");
    c_erase: cover property ($rose(flash_erase_o));
    c_block: cover property ($rose(flash_prog_o) && flash_bmask_o == 2'h3);
    c_err: cover property ($rose(flash_error_reset_o));
endmodule // fkwe_ctrl_chk

bind fkwe_ctrl fkwe_ctrl_chk u_chk (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sys_rst_i(sys_rst_i), .key_wr_i(key_wr_i),
    .store_write_enable_i(store_write_enable_i), .store_erase_enable_i(store_erase_enable_i),
    .supply_monitor_on_i(supply_monitor_on_i), .supply_reset_src_en_i(supply_reset_src_en_i),
    .st_valid_i(st_valid_i), .st_data_i(st_data_i), .flash_rdata_i(flash_rdata_i),
    .xram_we_o(xram_we_o), .xram_wdata_o(xram_wdata_o), .flash_addr_o(flash_addr_o),
    .flash_wdata_o(flash_wdata_o), .flash_bmask_o(flash_bmask_o), .flash_prog_o(flash_prog_o),
    .flash_erase_o(flash_erase_o), .cpu_stall_o(cpu_stall_o), .key_state_o(key_state_o),
    .flash_error_reset_o(flash_error_reset_o));

// file: bench/fkwe_flash_model.sv
// flash array model, two pages, written when an operation starts
// assumes the controller holds address and data at op start
module fkwe_flash_model (
    input  wire logic        ref_clk_i,
    input  wire logic [15:0] rd_addr_i,
    input  wire logic [15:0] flash_addr_i,
    input  wire logic [15:0] flash_wdata_i,
    input  wire logic [1:0]  flash_bmask_i,
    input  wire logic        flash_prog_i,
    input  wire logic        flash_erase_i,
    output logic      [15:0] flash_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    logic       prog_q;
    logic       erase_q;
    integer     i;
    logic [9:0] ev;
    assign ev = {flash_addr_i[9:1], 1'b0};
    initial for (i = 0; i < 1024; i = i + 1) mem[i] = 8'hFF;
    assign flash_rdata_o = {mem[{rd_addr_i[9:1], 1'b1}], mem[{rd_addr_i[9:1], 1'b0}]};
    always @(posedge ref_clk_i) begin
        prog_q  <= flash_prog_i;
        erase_q <= flash_erase_i;
        // cells only go from one to zero
        if (flash_prog_i && !prog_q) begin
            if (flash_bmask_i[0]) mem[ev] <= mem[ev] & flash_wdata_i[7:0];
            if (flash_bmask_i[1]) mem[ev | 10'h001] <= mem[ev | 10'h001] & flash_wdata_i[15:8];
        end
        if (flash_erase_i && !erase_q) begin
            for (i = 0; i < 512; i = i + 1) mem[{flash_addr_i[9], i[8:0]}] <= 8'hFF;
        end
    end
endmodule // fkwe_flash_model

// file: bench/tb.sv
// testbench for the key, write and erase sequencer
// assumes short operation counts and the flash model beside it
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, srst, kw, we, ee, bw, mon, src, sv, xwe, fp, fe, stall, err, ind;
    logic [7:0] kd, sd, xd;
    logic [15:0] sa, rdata, xa, fa, fwd;
    logic [1:0] fbm, ks;
    integer mismatches, n_compared, cyc, k;
    integer n_xw = 0;
    integer last_n, nb;
    // count xram write pulses
    always @(posedge clk) if (xwe === 1'b1) n_xw <= n_xw + 1;
    fkwe_ctrl #(.PROG_CYCLES(5), .ERASE_CYCLES(20)) dut (
        .ref_clk_i(clk), .rst_b_i(rst_b), .sys_rst_i(srst), .key_wr_i(kw), .key_data_i(kd),
        .store_write_enable_i(we), .store_erase_enable_i(ee), .block_write_select_i(bw),
        .supply_monitor_on_i(mon), .supply_reset_src_en_i(src), .st_valid_i(sv), .st_addr_i(sa),
        .st_data_i(sd), .flash_rdata_i(rdata), .xram_we_o(xwe), .xram_addr_o(xa),
        .xram_wdata_o(xd), .flash_addr_o(fa), .flash_wdata_o(fwd), .flash_bmask_o(fbm),
        .flash_prog_o(fp), .flash_erase_o(fe), .cpu_stall_o(stall), .key_state_o(ks),
        .flash_error_reset_o(err), .flash_error_indicator_o(ind));
    fkwe_flash_model fm (.ref_clk_i(clk), .rd_addr_i(sa), .flash_addr_i(fa), .flash_wdata_i(fwd),
        .flash_bmask_i(fbm), .flash_prog_i(fp), .flash_erase_i(fe), .flash_rdata_o(rdata));
    always #20 clk = ~clk;
    // ****************************************
    // tasks
    // ****************************************
    task finish_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    task chk(input [15:0] g, input [15:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task key(input [7:0] b);
        begin @(posedge clk); #1 kw = 1; kd = b; @(posedge clk); #1 kw = 0; end
    endtask
    task ul;
        begin key(8'hA5); key(8'hF1); end
    endtask
    task pulse_srst;
        begin @(posedge clk); #1 srst = 1; @(posedge clk); #1 srst = 0; end
    endtask
    task st(input [15:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk); #1 sa = a; sd = d; sv = 1;
            @(posedge clk); #1 sv = 0;
            while (stall !== 1'b0 && n < 100) begin @(posedge clk); #1 n = n + 1; end
            if (n >= 100) begin
                mismatches = mismatches + 1;
                $display("BAD %0t stall stuck", $time);
            end
            last_n = n;
            @(posedge clk); #1;
        end
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        clk = 0; rst_b = 0; srst = 0; kw = 0; kd = 0; we = 0; ee = 0; bw = 0;
        sv = 0; sa = 0; sd = 0; mismatches = 0; n_compared = 0; cyc = 0;
        mon = 1; src = 1;
        repeat (3) @(posedge clk);
        #1 rst_b = 1;
        we = 1;
        ul; st(16'h0200, 8'h00); chk(fm.mem[10'h200], 8'h00);
        chk(ks, 2'h0);
        ul; st(16'h0010, 8'h5A); ul; st(16'h0010, 8'hA5); chk(fm.mem[10'h010], 8'h00);
        $display("test byte program done");
        nb = last_n;
        bw = 1; ul; st(16'h0020, 8'h12); chk(fm.mem[10'h020], 8'hFF);
        ul; st(16'h0021, 8'h34); chk({fm.mem[10'h021], fm.mem[10'h020]}, 16'h3412);
        ul; st(16'h0020, 8'hFF); ul; st(16'h0021, 8'h30);
        chk({fm.mem[10'h021], fm.mem[10'h020]}, 16'h3012);
        chk(last_n[15:0], nb[15:0]);
        bw = 0; ee = 1; ul; st(16'h0155, 8'h00); ee = 0;
        chk({fm.mem[10'h021], fm.mem[10'h010]}, 16'hFFFF);
        chk(fm.mem[10'h200], 8'h00);
        $display("test block and erase done");
        we = 0; key(8'hA5); st(16'h0030, 8'h77); chk(ks, 2'h1);
        chk(n_xw[15:0], 16'h0001); chk(xa, 16'h0030); chk(xd, 8'h77);
        repeat (30) @(posedge clk);
        #1 key(8'hF1); chk(ks, 2'h2);
        we = 1; st(16'h0030, 8'h77); chk(fm.mem[10'h030], 8'h77);
        ul; st(16'h0031, 8'hC3); chk({fm.mem[10'h031], fm.mem[10'h030]}, 16'hC377);
        key(8'h11); chk(ks, 2'h3);
        ul; st(16'h0040, 8'h00); chk(fm.mem[10'h040], 8'hFF);
        pulse_srst; chk(ks, 2'h0);
        st(16'h0040, 8'h00); chk(ks, 2'h3);
        pulse_srst;
        $display("test key sequence done");
        for (k = 0; k < 2; k = k + 1) begin
            ul; mon = k[0]; src = !k[0]; st(16'h0040, 8'h00);
            chk({err, fm.mem[10'h040]}, 9'h1FF);
            mon = 1; src = 1; pulse_srst; chk({ind, err}, 2'h2);
        end
        $display("test supply error done");
        finish_test;
    end
endmodule // tb
